// File: core/irq_pkg.sv
// constants, register map and types shared by the interrupt latch and priority unit
`default_nettype none
package irq_pkg;
	// ****************************************
	// sources
	// ****************************************
	localparam int         NUM_SRC    = 24;
	localparam logic [4:0] SRC_SWI    = 5'h00;
	localparam logic [4:0] SRC_UNDEF  = 5'h01;
	localparam logic [4:0] SRC_TRAP   = 5'h02;
	localparam logic [4:0] SRC_WDT    = 5'h03;
	localparam logic [4:0] SRC_MASK   = 5'h04;
	localparam logic [4:0] SRC_ADC    = 5'h0F;
	localparam logic [4:0] SRC_SPLIT  = 5'h10;
	localparam int         LATCH_LO   = 2;
	localparam int         MASK_LO    = 4;
	localparam int         BYTE_BITS  = 8;

	// ****************************************
	// vectors
	// ****************************************
	localparam logic [15:0] VEC_RESET   = 16'hFFFE;
	localparam logic [15:0] VEC_SWI     = 16'hFFFC;
	localparam logic [15:0] VEC_TRAP    = 16'hFFFA;
	localparam logic [15:0] VEC_WDT     = 16'hFFF8;
	localparam logic [15:0] VEC_LO_BASE = 16'hFFF6;
	localparam logic [15:0] VEC_HI_BASE = 16'hFFBE;
	localparam logic [15:0] VEC_STEP    = 16'h0002;

	// ****************************************
	// acceptance sequence
	// ****************************************
	localparam logic [2:0] CNT_FIRST    = 3'h0;
	localparam logic [2:0] CNT_LAST     = 3'h7;
	localparam logic [2:0] CNT_PUSH_PCH = 3'h1;
	localparam logic [2:0] CNT_PUSH_PCL = 3'h2;
	localparam logic [2:0] CNT_PUSH_END = 3'h3;
	localparam logic [2:0] CNT_LOAD     = 3'h6;
	localparam logic [2:0] CNT_ONE      = 3'h1;

	// ****************************************
	// register indices and byte addresses
	// ****************************************
	localparam logic [7:0] IDX_LATCH_EXT  = 8'h2E;
	localparam logic [7:0] IDX_LATCH_LOW  = 8'h3C;
	localparam logic [7:0] IDX_LATCH_HIGH = 8'h3D;
	localparam logic [7:0] IDX_EN_EXT     = 8'h2C;
	localparam logic [7:0] IDX_EN_LOW     = 8'h3A;
	localparam logic [7:0] IDX_EN_HIGH    = 8'h3B;
	localparam logic [7:0] IDX_CTRL       = 8'h40;
	localparam logic [7:0] IDX_STAT       = 8'h41;
	localparam logic [9:0] ADR_LATCH_EXT  = {IDX_LATCH_EXT, 2'b00};
	localparam logic [9:0] ADR_LATCH_LOW  = {IDX_LATCH_LOW, 2'b00};
	localparam logic [9:0] ADR_LATCH_HIGH = {IDX_LATCH_HIGH, 2'b00};
	localparam logic [9:0] ADR_EN_EXT     = {IDX_EN_EXT, 2'b00};
	localparam logic [9:0] ADR_EN_LOW     = {IDX_EN_LOW, 2'b00};
	localparam logic [9:0] ADR_EN_HIGH    = {IDX_EN_HIGH, 2'b00};
	localparam logic [9:0] ADR_CTRL       = {IDX_CTRL, 2'b00};
	localparam logic [9:0] ADR_STAT       = {IDX_STAT, 2'b00};

	// ****************************************
	// fields
	// ****************************************
	localparam int         IMF_BIT       = 0;
	localparam int         CTRL_TRAP_SEL = 0;
	localparam int         CTRL_WDT_SEL  = 1;
	localparam int         CTRL_EXT0_EN  = 2;
	localparam logic [2:0] CTRL_RESET    = 3'h3;
	localparam int         STAT_BUSY     = 0;
	localparam int         STAT_HAZARD   = 1;
	localparam int         STAT_IMF      = 2;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_ACCEPT = 1'b1
	} accept_state_e;
endpackage
`default_nettype wire

// File: core/irq_priority.sv
// fixed priority resolver: lowest set position wins
`default_nettype none
module irq_priority (
	input  wire logic [23:0] requests,
	output logic             found,
	output logic [4:0]       winner
);
	always_comb begin
		found  = 1'b0;
		winner = 5'h00;
		for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (requests[i]) begin
				found  = 1'b1;
				winner = 5'(i);
			end
		end
	end
endmodule // irq_priority
`default_nettype wire

// File: core/irq_status_mux.sv
// read-back multiplexer for the register file
`default_nettype none
module irq_status_mux (
	input  wire logic [9:0]  adr,
	input  wire logic [23:0] pend,
	input  wire logic [23:4] enable,
	input  wire logic        global_irq_enable,
	input  wire logic [2:0]  ctrl,
	input  wire logic [2:0]  stat,
	output logic [7:0]       rdByte
);
	always_comb begin
		case (adr)
			irq_pkg::ADR_LATCH_LOW:  rdByte = pend[7:0];
			irq_pkg::ADR_LATCH_HIGH: rdByte = pend[15:8];
			irq_pkg::ADR_LATCH_EXT:  rdByte = pend[23:16];
			irq_pkg::ADR_EN_LOW:     rdByte = {enable[7:4], 3'h0, global_irq_enable};
			irq_pkg::ADR_EN_HIGH:    rdByte = enable[15:8];
			irq_pkg::ADR_EN_EXT:     rdByte = enable[23:16];
			irq_pkg::ADR_CTRL:       rdByte = {5'h00, ctrl};
			irq_pkg::ADR_STAT:       rdByte = {5'h00, stat};
			default:                 rdByte = 8'h00;
		endcase
	end
endmodule // irq_status_mux
`default_nettype wire

// File: core/interrupt_latch_priority_unit.sv
// interrupt latches, enables, priority selection and acceptance sequencer
//
// Register access over Wishbone is this design's own decision.
`default_nettype none
module interrupt_latch_priority_unit (
	input  wire logic        clk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire logic [9:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        stb_i,
	input  wire logic        cyc_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// peripheral request events
	input  wire logic [23:2] requestEvent,
	// cpu core
	input  wire logic        instrBoundary,
	input  wire logic        softwareTrap,
	input  wire logic        undefinedOpcodeTrap,
	input  wire logic [15:0] programCounter,
	input  wire logic [7:0]  statusWord,
	input  wire logic        returnStrobe,
	input  wire logic        restoredImf,
	output logic             irqRequest,
	output logic             acceptBusy,
	output logic             stackPush,
	output logic [7:0]       stackData,
	output logic             vectorLoad,
	output logic [15:0]      vectorAddr,
	output logic             resetRequest
);
	// ****************************************
	// state
	// ****************************************
	logic [23:0]                   pend;
	logic [23:4]                   enable;
	logic                          global_irq_enable;
	logic [2:0]                    ctrl;
	logic                          hazard;
	irq_pkg::accept_state_e        state;
	logic [2:0]                    cnt;
	logic [15:0]                   pcHold;
	logic [7:0]                    pswHold;
	logic [15:0]                   vecHold;

	logic [23:0] reqVec;
	logic        found;
	logic [4:0]  winIdx;
	logic        startAccept;
	logic [23:0] acceptClr;
	logic [23:0] setEv;
	logic        busTake;
	logic        busWrite;
	logic [2:0]  latchWr;
	logic [7:0]  rdByte;

	// ****************************************
	// bus decode
	// ****************************************
	assign busTake  = cyc_i & stb_i & ~ack_o;
	assign busWrite = busTake & we_i & sel_i[0];
	assign latchWr  = {busWrite & (adr_i == irq_pkg::ADR_LATCH_EXT),
	                   busWrite & (adr_i == irq_pkg::ADR_LATCH_HIGH),
	                   busWrite & (adr_i == irq_pkg::ADR_LATCH_LOW)};

	// ****************************************
	// request vector and priority
	// ****************************************
	// the two instruction traps carry no latch, they are live levels from the core
	assign reqVec[irq_pkg::SRC_SWI]   = softwareTrap;
	assign reqVec[irq_pkg::SRC_UNDEF] = undefinedOpcodeTrap;
	assign reqVec[irq_pkg::SRC_TRAP]  = pend[irq_pkg::SRC_TRAP];
	assign reqVec[irq_pkg::SRC_WDT]   = pend[irq_pkg::SRC_WDT];

	generate
		for (genvar m = irq_pkg::MASK_LO; m < irq_pkg::NUM_SRC; m++) begin : g_mask
			if (m == irq_pkg::MASK_LO) begin : g_ext0
				assign reqVec[m] = pend[m] & enable[m] & global_irq_enable & ctrl[irq_pkg::CTRL_EXT0_EN];
			end else begin : g_plain
				assign reqVec[m] = pend[m] & enable[m] & global_irq_enable;
			end
		end
	endgenerate

	irq_priority u_priority (
		.requests (reqVec),
		.found    (found),
		.winner   (winIdx)
	);

	// only sampled at the boundary so a late request cannot change a running sequence
	assign startAccept = (state == irq_pkg::ST_IDLE) & instrBoundary & found;

	function automatic logic [15:0] vecFor(input logic [4:0] idx);
		if (idx < irq_pkg::SRC_TRAP) begin
			vecFor = irq_pkg::VEC_SWI;
		end else if (idx == irq_pkg::SRC_TRAP) begin
			vecFor = irq_pkg::VEC_TRAP;
		end else if (idx == irq_pkg::SRC_WDT) begin
			vecFor = irq_pkg::VEC_WDT;
		end else if (idx < irq_pkg::SRC_SPLIT) begin
			vecFor = 16'(irq_pkg::VEC_LO_BASE - 16'(16'(idx - irq_pkg::SRC_MASK) * irq_pkg::VEC_STEP));
		end else begin
			vecFor = 16'(irq_pkg::VEC_HI_BASE - 16'(16'(idx - irq_pkg::SRC_SPLIT) * irq_pkg::VEC_STEP));
		end
	endfunction

	// ****************************************
	// pending latches
	// ****************************************
	assign pend[1:0]      = 2'b00;
	assign setEv[1:0]     = 2'b00;
	assign acceptClr[1:0] = 2'b00;

	generate
		for (genvar i = irq_pkg::LATCH_LO; i < irq_pkg::NUM_SRC; i++) begin : g_latch
			localparam int BYTE = i / irq_pkg::BYTE_BITS;
			localparam int BIT  = i % irq_pkg::BYTE_BITS;
			logic swClr;
			if (i == irq_pkg::SRC_TRAP) begin : g_trap
				// with reset selected the event goes out as a reset request instead
				assign setEv[i] = requestEvent[i] & ~ctrl[irq_pkg::CTRL_TRAP_SEL];
			end else if (i == irq_pkg::SRC_WDT) begin : g_wdt
				assign setEv[i] = requestEvent[i] & ~ctrl[irq_pkg::CTRL_WDT_SEL];
			end else begin : g_src
				assign setEv[i] = requestEvent[i];
			end
			assign acceptClr[i] = startAccept & (winIdx == 5'(i));
			assign swClr        = latchWr[BYTE] & ~dat_i[BIT];
			always_ff @(posedge clk) begin
				if (!nrst) begin
					pend[i] <= 1'b0;
				end else if (setEv[i]) begin
					pend[i] <= 1'b1;
				end else if (acceptClr[i] | swClr) begin
					pend[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// enables and master enable
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			enable <= '0;
		end else if (busWrite) begin
			if (adr_i == irq_pkg::ADR_EN_LOW) begin
				enable[7:4] <= dat_i[7:4];
			end
			if (adr_i == irq_pkg::ADR_EN_HIGH) begin
				enable[15:8] <= dat_i[7:0];
			end
			if (adr_i == irq_pkg::ADR_EN_EXT) begin
				enable[23:16] <= dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			global_irq_enable <= 1'b0;
		end else if (startAccept) begin
			global_irq_enable <= 1'b0;
		end else if (returnStrobe) begin
			global_irq_enable <= restoredImf;
		end else if (busWrite && adr_i == irq_pkg::ADR_EN_LOW) begin
			global_irq_enable <= dat_i[irq_pkg::IMF_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= irq_pkg::CTRL_RESET;
		end else if (busWrite && adr_i == irq_pkg::ADR_CTRL) begin
			ctrl <= dat_i[2:0];
		end
	end

	// converter-done racing a lower-priority acceptance; the latch is kept, only flagged
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hazard <= 1'b0;
		end else if (startAccept && winIdx > irq_pkg::SRC_ADC && requestEvent[irq_pkg::SRC_ADC]) begin
			hazard <= 1'b1;
		end else if (busWrite && adr_i == irq_pkg::ADR_STAT && dat_i[irq_pkg::STAT_HAZARD]) begin
			hazard <= 1'b0;
		end
	end

	// ****************************************
	// acceptance sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= irq_pkg::ST_IDLE;
			cnt   <= irq_pkg::CNT_FIRST;
		end else begin
			case (state)
				irq_pkg::ST_IDLE: begin
					if (startAccept) begin
						state <= irq_pkg::ST_ACCEPT;
						cnt   <= irq_pkg::CNT_FIRST;
					end
				end
				irq_pkg::ST_ACCEPT: begin
					if (cnt == irq_pkg::CNT_LAST) begin
						state <= irq_pkg::ST_IDLE;
					end else begin
						cnt <= 3'(cnt + irq_pkg::CNT_ONE);
					end
				end
				default: begin
					state <= irq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pcHold  <= 16'h0000;
			pswHold <= 8'h00;
			vecHold <= irq_pkg::VEC_RESET;
		end else if (startAccept) begin
			pcHold  <= programCounter;
			pswHold <= {statusWord[7:1], global_irq_enable}; // status stacked with the enable in use
			vecHold <= vecFor(winIdx);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			acceptBusy <= 1'b0;
			stackPush  <= 1'b0;
			stackData  <= 8'h00;
			vectorLoad <= 1'b0;
			vectorAddr <= irq_pkg::VEC_RESET;
		end else begin
			acceptBusy <= startAccept | (state == irq_pkg::ST_ACCEPT && cnt != irq_pkg::CNT_LAST);
			stackPush  <= (state == irq_pkg::ST_ACCEPT) && (cnt < irq_pkg::CNT_PUSH_END);
			case (cnt)
				irq_pkg::CNT_FIRST:    stackData <= pswHold;
				irq_pkg::CNT_PUSH_PCH: stackData <= pcHold[15:8];
				irq_pkg::CNT_PUSH_PCL: stackData <= pcHold[7:0];
				default:               stackData <= 8'h00;
			endcase
			vectorLoad <= (state == irq_pkg::ST_ACCEPT) && (cnt == irq_pkg::CNT_LOAD);
			if (state == irq_pkg::ST_ACCEPT && cnt == irq_pkg::CNT_LOAD) begin
				vectorAddr <= vecHold;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			irqRequest   <= 1'b0;
			resetRequest <= 1'b0;
		end else begin
			irqRequest   <= found;
			resetRequest <= (requestEvent[irq_pkg::SRC_TRAP] & ctrl[irq_pkg::CTRL_TRAP_SEL]) |
			                (requestEvent[irq_pkg::SRC_WDT] & ctrl[irq_pkg::CTRL_WDT_SEL]);
		end
	end

	// ****************************************
	// wishbone answer
	// ****************************************
	irq_status_mux u_mux (
		.adr    (adr_i),
		.pend   (pend),
		.enable (enable),
		.global_irq_enable    (global_irq_enable),
		.ctrl   (ctrl),
		.stat   ({global_irq_enable, hazard, acceptBusy}),
		.rdByte (rdByte)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= busTake;
			if (busTake && !we_i) begin
				dat_o <= 32'(rdByte);
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_latch_reset: assert property (disable iff (1'b0) !nrst |=> pend == 24'h000000)
		else $error("latches not cleared by reset");
	a_mask_gate: assert property (startAccept && winIdx >= irq_pkg::SRC_MASK |-> global_irq_enable && enable[winIdx])
		else $error("maskable source accepted while disabled");
	a_accept_clear: assert property (startAccept && winIdx >= irq_pkg::SRC_TRAP && !setEv[winIdx]
		|=> !pend[$past(winIdx)])
		else $error("accepted latch still pending");
	a_imf_entry: assert property (startAccept |=> !global_irq_enable ##1 !global_irq_enable)
		else $error("master enable not cleared on acceptance");
	a_accept_len: assert property ($rose(acceptBusy) |-> acceptBusy[*8] ##1 !acceptBusy)
		else $error("acceptance not eight cycles");
	a_push_three: assert property ($rose(acceptBusy) |-> !stackPush ##1 stackPush[*3] ##1 !stackPush)
		else $error("stack push count wrong");
	a_vector_load: assert property (startAccept |=> ##7 vectorLoad && vectorAddr == $past(vecHold))
		else $error("vector not loaded at end of acceptance");
	a_write_one: assert property (latchWr[0] && dat_i[4] && pend[4] && !acceptClr[4] |=> pend[4])
		else $error("writing one cleared a latch");
	a_sw_clear: assert property (latchWr[1] && !dat_i[5] && !setEv[13] |=> pend[13] == 1'b0)
		else $error("software clear ignored");
	a_return_from_maskable_imf: assert property (returnStrobe && !startAccept && !busWrite |=> global_irq_enable == $past(restoredImf))
		else $error("master enable not restored");
	a_ext0_gate: assert property (startAccept && winIdx == irq_pkg::SRC_MASK |-> ctrl[irq_pkg::CTRL_EXT0_EN])
		else $error("external zero requested without pin enable");
	a_lowest_wins: assert property (startAccept && reqVec[irq_pkg::SRC_WDT] |-> winIdx <= irq_pkg::SRC_WDT)
		else $error("maskable beat non-maskable");

	c_mask_accept: cover property (startAccept && winIdx > irq_pkg::SRC_WDT);
	c_trap_accept: cover property (startAccept && winIdx == irq_pkg::SRC_TRAP);
	c_return_from_maskable: cover property (returnStrobe && restoredImf);
	c_hazard: cover property ($rose(hazard));
endmodule // interrupt_latch_priority_unit
`default_nettype wire

// File: sim/cpu_core_model.sv
// cpu core model: offers instruction boundaries, captures stack pushes and vector loads
`default_nettype none
module cpu_core_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        run,
	input  wire logic        slow,
	input  wire logic        acceptBusy,
	input  wire logic        stackPush,
	input  wire logic [7:0]  stackData,
	input  wire logic        vectorLoad,
	input  wire logic [15:0] vectorAddr,
	output logic             instrBoundary,
	output logic [15:0]      programCounter,
	output logic [7:0]       statusWord,
	output logic [23:0]      pushed,
	output logic [15:0]      vecSeen,
	output logic [7:0]       vecCount
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] gap;
	assign programCounter = 16'h1234;
	assign statusWord     = 8'hA5;
	// no boundary while an acceptance runs; slow mode spaces them four cycles apart
	always_ff @(posedge clk) begin
		if (!nrst) begin
			instrBoundary <= 1'h0;
			gap           <= 2'h0;
		end else begin
			gap           <= gap + 2'h1;
			instrBoundary <= run && !acceptBusy && !instrBoundary && (!slow || gap == 2'h3);
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pushed   <= 24'h000000;
			vecSeen  <= 16'h0000;
			vecCount <= 8'h00;
		end else begin
			if (stackPush)
				pushed <= {pushed[15:0], stackData};
			if (vectorLoad) begin
				vecSeen  <= vectorAddr;
				vecCount <= vecCount + 8'h01;
			end
		end
	end
endmodule // cpu_core_model
`default_nettype wire

// File: sim/interrupt_latch_priority_unit_bench.sv
// self-checking bench for the interrupt latch and priority unit
`default_nettype none
module interrupt_latch_priority_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, we_i, stb_i, cyc_i, ack_o, instrBoundary, softwareTrap, undefinedOpcodeTrap;
	logic        returnStrobe, restoredImf, irqRequest, acceptBusy, stackPush, vectorLoad, resetRequest;
	logic        run, slow;
	logic [3:0]  sel_i;
	logic [7:0]  statusWord, stackData, vecCount, rstCount, busyCount, lastBusy;
	logic [9:0]  adr_i;
	logic [15:0] programCounter, vectorAddr, vecSeen;
	logic [23:0] pushed;
	logic [23:2] requestEvent;
	logic [31:0] dat_i, dat_o;
	int          nFail, totalChecks;

	interrupt_latch_priority_unit dut_u (
		.clk(clk), .nrst(nrst), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
		.stb_i(stb_i), .cyc_i(cyc_i), .dat_o(dat_o), .ack_o(ack_o), .requestEvent(requestEvent),
		.instrBoundary(instrBoundary), .softwareTrap(softwareTrap), .undefinedOpcodeTrap(undefinedOpcodeTrap),
		.programCounter(programCounter), .statusWord(statusWord), .returnStrobe(returnStrobe),
		.restoredImf(restoredImf), .irqRequest(irqRequest), .acceptBusy(acceptBusy), .stackPush(stackPush),
		.stackData(stackData), .vectorLoad(vectorLoad), .vectorAddr(vectorAddr), .resetRequest(resetRequest)
	);
	cpu_core_model core_u (
		.clk(clk), .nrst(nrst), .run(run), .slow(slow), .acceptBusy(acceptBusy), .stackPush(stackPush),
		.stackData(stackData), .vectorLoad(vectorLoad), .vectorAddr(vectorAddr),
		.instrBoundary(instrBoundary), .programCounter(programCounter), .statusWord(statusWord),
		.pushed(pushed), .vecSeen(vecSeen), .vecCount(vecCount)
	);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// acceptance length and reset-request pulses seen at the pins
	always @(posedge clk) begin
		if (acceptBusy === 1'h1)
			busyCount <= busyCount + 8'h01;
		else if (busyCount != 8'h00) begin
			lastBusy  <= busyCount;
			busyCount <= 8'h00;
		end
		if (resetRequest === 1'h1)
			rstCount <= rstCount + 8'h01;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d failures %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// waits on ack without assuming a latency
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
		int i;
		@(posedge clk);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack_o !== 1'h1 && i < 20);
		q = dat_o[7:0];
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i  <= 1'h0;
		if (i >= 20)
			chk(16'h0000, 16'hFFFF);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'h0, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'h1, a, d, q);
	endtask
	task automatic pulse(input logic [23:2] m);
		@(posedge clk);
		requestEvent <= m;
		@(posedge clk);
		requestEvent <= '0;
	endtask
	task automatic accept(input logic [15:0] v, input logic [7:0] st);
		logic [7:0] c;
		int i;
		c = vecCount;
		i = 0;
		while (vecCount === c && i < 60) begin
			@(posedge clk);
			i++;
			if (acceptBusy === 1'h1) begin
				softwareTrap        <= 1'h0;
				undefinedOpcodeTrap <= 1'h0;
			end
		end
		repeat (2) @(posedge clk);
		chk({8'h00, vecCount - c}, 16'h0001);
		chk(vecSeen, v);
		chk(pushed[23:8], {st, 8'h12});
		chk({8'h00, pushed[7:0]}, 16'h0034);
		chk({8'h00, lastBusy}, 16'h0008);
	endtask
	task automatic quiet();
		logic [7:0] c;
		c = vecCount;
		repeat (24) @(posedge clk);
		chk({8'h00, vecCount}, {8'h00, c});
	endtask
	function automatic logic [15:0] vecOf(input int n);
		return (n < 16) ? 16'(32'hFFF6 - 2 * (n - 4)) : 16'(32'hFFBE - 2 * (n - 16));
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk(vectorAddr, 16'hFFFE);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h00);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'h00);
		rd(irq_pkg::ADR_LATCH_EXT, 8'h00);
		rd(irq_pkg::ADR_EN_LOW, 8'h00);
		rd(irq_pkg::ADR_EN_HIGH, 8'h00);
		rd(irq_pkg::ADR_EN_EXT, 8'h00);
		rd(irq_pkg::ADR_CTRL, 8'h03);
		wr(10'h3FC, 8'hFF);
		rd(10'h3FC, 8'h00);
	endtask
	// one event pulse sets latches 4, 7, 9, 17 and 23; written ones keep them, written zeros clear them
	task automatic t_latch();
		pulse(22'h2080A4);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h90);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'h02);
		rd(irq_pkg::ADR_LATCH_EXT, 8'h82);
		wr(irq_pkg::ADR_LATCH_LOW, 8'hFF);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h90);
		wr(irq_pkg::ADR_LATCH_LOW, 8'hEF);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h80);
		wr(irq_pkg::ADR_LATCH_EXT, 8'h7F);
		rd(irq_pkg::ADR_LATCH_EXT, 8'h02);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'h02);
		wr(irq_pkg::ADR_LATCH_LOW, 8'h0F);
		wr(irq_pkg::ADR_LATCH_HIGH, 8'h00);
		wr(irq_pkg::ADR_LATCH_EXT, 8'h00);
	endtask
	task automatic t_mask();
		wr(irq_pkg::ADR_CTRL, 8'h00);
		run <= 1'h1;
		pulse(22'h000008);
		wr(irq_pkg::ADR_EN_LOW, 8'h01);
		quiet();
		chk({15'h0000, irqRequest}, 16'h0000);
		wr(irq_pkg::ADR_EN_LOW, 8'h20);
		quiet();
		wr(irq_pkg::ADR_EN_LOW, 8'h21);
		accept(16'hFFF4, 8'hA5);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h00);
		rd(irq_pkg::ADR_EN_LOW, 8'h20);
		pulse(22'h000004);
		wr(irq_pkg::ADR_EN_LOW, 8'h11);
		quiet();
		wr(irq_pkg::ADR_CTRL, 8'h04);
		accept(16'hFFF6, 8'hA5);
	endtask
	// adjacent pairs raised together: the lower position must be taken first
	task automatic t_prio();
		logic [23:0] m;
		slow <= 1'h1;
		wr(irq_pkg::ADR_EN_HIGH, 8'hFF);
		wr(irq_pkg::ADR_EN_EXT, 8'hFF);
		wr(irq_pkg::ADR_EN_LOW, 8'hF0);
		for (int n = 4; n < 24; n += 2) begin
			m = 24'h000003 << n;
			pulse(m[23:2]);
			wr(irq_pkg::ADR_EN_LOW, 8'hF1);
			accept(vecOf(n), 8'hA5);
			wr(irq_pkg::ADR_EN_LOW, 8'hF1);
			accept(vecOf(n + 1), 8'hA5);
		end
		slow <= 1'h0;
	endtask
	task automatic t_nmi();
		wr(irq_pkg::ADR_CTRL, 8'h03);
		pulse(22'h000001);
		pulse(22'h000002);
		repeat (2) @(posedge clk);
		chk({8'h00, rstCount}, 16'h0002);
		rd(irq_pkg::ADR_LATCH_LOW, 8'h00);
		wr(irq_pkg::ADR_CTRL, 8'h04);
		run <= 1'h0;
		pulse(22'h00000A);
		wr(irq_pkg::ADR_EN_LOW, 8'h21);
		chk({15'h0000, irqRequest}, 16'h0001);
		run <= 1'h1;
		accept(16'hFFF8, 8'hA5);
		wr(irq_pkg::ADR_EN_LOW, 8'h21);
		accept(16'hFFF4, 8'hA5);
		pulse(22'h000003);
		accept(16'hFFFA, 8'hA4);
		accept(16'hFFF8, 8'hA4);
		softwareTrap <= 1'h1;
		accept(16'hFFFC, 8'hA4);
		undefinedOpcodeTrap <= 1'h1;
		accept(16'hFFFC, 8'hA4);
	endtask
	task automatic t_ret();
		run <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			returnStrobe <= 1'h1;
			restoredImf  <= (k == 0);
			@(posedge clk);
			returnStrobe <= 1'h0;
			rd(irq_pkg::ADR_EN_LOW, (k == 0) ? 8'h21 : 8'h20);
		end
	endtask
	// converter-done lands on the very edge that accepts source twenty
	task automatic t_hazard();
		wr(irq_pkg::ADR_EN_EXT, 8'h10);
		pulse(22'h040000);
		wr(irq_pkg::ADR_EN_LOW, 8'h01);
		@(posedge clk);
		run <= 1'h1;
		@(posedge clk);
		requestEvent <= 22'h002000;
		@(posedge clk);
		requestEvent <= '0;
		accept(16'hFFB6, 8'hA5);
		rd(irq_pkg::ADR_STAT, 8'h02);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'h80);
		wr(irq_pkg::ADR_STAT, 8'h02);
		rd(irq_pkg::ADR_STAT, 8'h00);
	endtask
	// reset in mid-run with latches, enables and a loaded vector in place
	task automatic t_rst2();
		wr(irq_pkg::ADR_EN_HIGH, 8'h5A);
		pulse(22'h3FFFFC);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'hFF);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		rd(irq_pkg::ADR_LATCH_LOW, 8'h00);
		rd(irq_pkg::ADR_LATCH_HIGH, 8'h00);
		rd(irq_pkg::ADR_LATCH_EXT, 8'h00);
		rd(irq_pkg::ADR_EN_LOW, 8'h00);
		rd(irq_pkg::ADR_EN_HIGH, 8'h00);
		rd(irq_pkg::ADR_CTRL, 8'h03);
		chk(vectorAddr, 16'hFFFE);
		chk({15'h0000, irqRequest}, 16'h0000);
	endtask

	initial begin
		nrst = 1'h0;
		{we_i, stb_i, cyc_i, softwareTrap, undefinedOpcodeTrap, returnStrobe, restoredImf, run, slow} = '0;
		sel_i = 4'hF;
		adr_i = 10'h000;
		dat_i = 32'h00000000;
		requestEvent = '0;
		{rstCount, busyCount, lastBusy} = '0;
		nFail = 0;
		totalChecks = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		t_reset();
		t_latch();
		t_mask();
		t_prio();
		t_nmi();
		t_ret();
		t_hazard();
		t_rst2();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk);
		nFail++;
		$display("ERROR at %0t: watchdog expired", $time);
		close_out();
	end
endmodule // interrupt_latch_priority_unit_bench
`default_nettype wire
